// *** design/out_skid.sv ***
// two-entry output buffer between the array read and the reader
`timescale 1ns/10ps
module out_skid #(
   parameter int WIDTH = 18
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             sys_rst,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   typedef struct packed {
      logic [1:0][WIDTH-1:0] slot;
      logic [1:0]            cnt;   // 0..2 words held
   } skid_t;

   skid_t st;
   skid_t next_st;

   assign in_ready  = (st.cnt != 2'h2);
   assign out_valid = (st.cnt != 2'h0);
   assign out_data  = st.slot[0];

   // shift register of two: slot 0 is always the head
   always_comb begin
      logic push;
      logic pop;
      push = in_valid && in_ready;
      pop  = out_valid && out_ready;
      next_st = st;
      if (pop) begin
         next_st.slot[0] = st.slot[1];
      end
      if (push) begin
         if (st.cnt == 2'h0 || (st.cnt == 2'h1 && pop)) begin
            next_st.slot[0] = in_data;
         end else begin
            next_st.slot[1] = in_data;
         end
      end
      next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule // out_skid

// *** design/sram_fifo_block.sv ***
// aspect-ratio dual-port sram block with embedded buffer controller
`timescale 1ns/10ps
// Function
// R1: 4608 bits total in every shape; the 1kx4, 2kx2 and 4kx1 shapes use 4096 of them
// R2: shapes 256x18, 512x9, 1kx4, 2kx2, 4kx1
// R3: independent write and read ports, own widths
// R4: preload from flash or test port
// R5: built-in controller makes a synchronous buffer
// R6: buffer width and depth set by configuration
// R7: full, empty, almost flags with thresholds
// R8: controller pointers generate all addresses
// R9: blocks can be cascaded deeper or wider
// R10: flag levels from entry count and thresholds
// R11: write when full, read when empty ignored
module sram_fifo_block #(
   parameter int DEPTH_MAX = 4096
) (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // configuration
   input  wire logic        fifo_mode,     // 1: buffer, 0: plain ram
   input  wire logic [2:0]  wr_width_sel,
   input  wire logic [2:0]  rd_width_sel,
   input  wire logic [12:0] fifo_depth,    // entries at write width
   input  wire logic [12:0] almost_full_level,
   input  wire logic [12:0] almost_empty_level,
   // preload from flash or user_test_port_access
   input  wire logic        init_en,
   input  wire logic [7:0]  init_addr,
   input  wire logic [17:0] init_data,
   // write port
   input  wire logic        wr_en,
   input  wire logic [11:0] wr_addr,
   input  wire logic [17:0] wr_data,
   output logic             wr_ready,
   // read port
   input  wire logic        rd_en,
   input  wire logic [11:0] rd_addr,
   output logic             rd_valid,
   input  wire logic        rd_ready,
   output logic      [17:0] rd_data,
   // status
   output logic             full_flag,
   output logic             empty_flag,
   output logic             almost_full_flag,
   output logic             almost_empty_flag,
   output logic      [12:0] fill_level
);

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   // log2 of the words per row: 18 and 9 handled as 16 and 8 lanes
   function automatic logic [2:0] shift_of(input logic [2:0] sel);
      case (sel)
         sram_fifo_pkg::W_18: shift_of = 3'h0;
         sram_fifo_pkg::W_9:  shift_of = 3'h1;
         sram_fifo_pkg::W_4:  shift_of = 3'h2;
         sram_fifo_pkg::W_2:  shift_of = 3'h3;
         default:             shift_of = 3'h4;
      endcase
   endfunction

   // bits per word for a width code
   function automatic logic [4:0] bits_of(input logic [2:0] sel);
      case (sel)
         sram_fifo_pkg::W_18: bits_of = 5'h12;
         sram_fifo_pkg::W_9:  bits_of = 5'h09;
         sram_fifo_pkg::W_4:  bits_of = 5'h04;
         sram_fifo_pkg::W_2:  bits_of = 5'h02;
         default:             bits_of = 5'h01;
      endcase
   endfunction

   // bit offset of a word within an 18-bit row
   function automatic logic [4:0] lane_of(input logic [2:0] sel,
                                           input logic [11:0] a);
      case (sel)
         sram_fifo_pkg::W_18: lane_of = 5'h00;
         sram_fifo_pkg::W_9:  lane_of = a[0] ? 5'h09 : 5'h00;
         sram_fifo_pkg::W_4:  lane_of = {1'b0, a[1:0], 2'b00};
         sram_fifo_pkg::W_2:  lane_of = {1'b0, a[2:0], 1'b0};
         default:             lane_of = {1'b0, a[3:0]};
      endcase
   endfunction

   // row index of a word address
   function automatic logic [7:0] row_of(input logic [2:0] sel,
                                          input logic [11:0] a);
      logic [11:0] r;
      r = a >> shift_of(sel);
      row_of = r[7:0];
   endfunction

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [sram_fifo_pkg::ROWS-1:0][sram_fifo_pkg::DATA_W-1:0] mem;
      logic [17:0] wptr;   // write pointer in bits
      logic [17:0] rptr;   // read pointer in bits
      logic [12:0] level;  // stored bits, the raw pointer difference of the cycle before
   } blk_t;

   blk_t st;
   blk_t next_st;

   logic        skid_ready;
   logic        rd_fire;
   logic        wr_fire;
   logic [17:0] rd_word;
   logic [4:0]  wbits;
   logic [4:0]  rbits;
   logic [17:0] cap_bits;
   logic [17:0] used_bits;
   logic [11:0] wa;
   logic [11:0] ra;

   assign wbits = bits_of(wr_width_sel);
   assign rbits = bits_of(rd_width_sel);
   // configured capacity in bits, clipped to the array
   assign cap_bits = (18'(fifo_depth) * 18'(wbits) >
                      18'(sram_fifo_pkg::TOTAL_BITS)) ?
                     18'(sram_fifo_pkg::TOTAL_BITS) :
                     18'(fifo_depth) * 18'(wbits);            // [R1] [R6]
   assign used_bits = st.wptr - st.rptr;

   // ---------------------------------------------------------------
   // address source: pointers in buffer mode, ports otherwise
   // ---------------------------------------------------------------
   // pointers run in bits so mixed widths share one fill count
   // the write pointer may sit one lap ahead until the read side wraps
   assign wa = fifo_mode ?
               12'(((st.wptr >= cap_bits) ? st.wptr - cap_bits : st.wptr) /
                   18'(wbits)) :
               wr_addr;                                             // [R8]
   assign ra = fifo_mode ? 12'(st.rptr[17:0] / 18'(rbits)) : rd_addr; // [R8]

   // flags from bit count; a partial read word counts as empty
   always_comb begin
      logic [17:0] lvl;
      lvl = used_bits / 18'(rbits);
      fill_level        = 13'(lvl);
      empty_flag        = used_bits < 18'(rbits);                  // [R10]
      full_flag         = used_bits + 18'(wbits) > cap_bits;       // [R10]
      almost_full_flag  = fill_level >= almost_full_level;         // [R7]
      almost_empty_flag = fill_level <= almost_empty_level;        // [R7]
   end

   // a write is refused in buffer mode when full, and during preload
   assign wr_ready = !(fifo_mode && full_flag) && !init_en;
   assign wr_fire  = wr_en && wr_ready;                             // [R11]
   // the read side feeds the skid buffer, so a stall loses no word
   assign rd_fire  = rd_en && skid_ready && !init_en &&
                     !(fifo_mode && empty_flag);                    // [R11]

   // read word extracted from its row and lane
   always_comb begin
      logic [17:0] row;
      row = st.mem[row_of(rd_width_sel, ra)];
      rd_word = (row >> lane_of(rd_width_sel, ra)) &
                ((18'h1 << rbits) - 18'h1);                         // [R3]
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic [17:0] mask;
      logic [4:0]  off;
      logic [7:0]  r;
      next_st = st;
      mask = 18'h0;
      off  = 5'h00;
      r    = 8'h00;
      if (init_en) begin
         next_st.mem[init_addr] = init_data;                        // [R4]
      end else if (wr_fire) begin
         // each shape maps onto the same 256 rows of 18 bits
         off  = lane_of(wr_width_sel, wa);                          // [R2]
         r    = row_of(wr_width_sel, wa);
         mask = ((18'h1 << wbits) - 18'h1) << off;
         next_st.mem[r] = (st.mem[r] & ~mask) |
                          ((wr_data << off) & mask);                // [R3]
      end
      if (fifo_mode) begin
         if (wr_fire) begin
            next_st.wptr = st.wptr + 18'(wbits);                    // [R5]
         end
         if (rd_fire) begin
            next_st.rptr = st.rptr + 18'(rbits);                    // [R5]
         end
      end else begin
         next_st.wptr = 18'h0;
         next_st.rptr = 18'h0;
      end
      // wrap both pointers together at the configured capacity
      if (next_st.rptr >= cap_bits && cap_bits != 18'h0) begin
         next_st.rptr = next_st.rptr - cap_bits;
         next_st.wptr = next_st.wptr - cap_bits;
      end
      next_st.level = 13'(used_bits);
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st.wptr  <= 18'h0;
         st.rptr  <= 18'h0;
         st.level <= sram_fifo_pkg::LVL_ZERO;
         st.mem   <= next_st.mem;   // contents survive reset
      end else begin
         st <= next_st;
      end
   end

   // ---------------------------------------------------------------
   // output buffer; cascade uses wr_ready/rd_valid as handshakes
   // ---------------------------------------------------------------
   out_skid #(
      .WIDTH (sram_fifo_pkg::DATA_W)
   ) u_skid (
      .core_clk  (core_clk),
      .sys_rst   (sys_rst),
      .in_valid  (rd_fire),
      .in_ready  (skid_ready),
      .in_data   (rd_word),
      .out_valid (rd_valid),                                        // [R9]
      .out_ready (rd_ready),
      .out_data  (rd_data)
   );

endmodule // sram_fifo_block

// *** pkg/sram_fifo_pkg.sv ***
// shared constants for the aspect-ratio sram block with buffer controller
package sram_fifo_pkg;

   // ---------------------------------------------------------------
   // storage geometry
   // ---------------------------------------------------------------
   localparam int TOTAL_BITS = 4608;   // 256 x 18 data bits
   localparam int ADDR_W     = 12;     // 4k x 1 is the deepest shape
   localparam int DATA_W     = 18;     // 256 x 18 is the widest shape
   localparam int ROWS       = 256;    // physical rows of 18 bits
   localparam int ROW_W      = 8;
   localparam int LVL_W      = 13;     // entry count up to 4608

   // ---------------------------------------------------------------
   // port width codes
   // ---------------------------------------------------------------
   localparam logic [2:0] W_18 = 3'h0;  // 256 x 18
   localparam logic [2:0] W_9  = 3'h1;  // 512 x 9
   localparam logic [2:0] W_4  = 3'h2;  // 1k x 4
   localparam logic [2:0] W_2  = 3'h3;  // 2k x 2
   localparam logic [2:0] W_1  = 3'h4;  // 4k x 1

   // ---------------------------------------------------------------
   // reset values and buffer geometry
   // ---------------------------------------------------------------
   localparam logic [LVL_W-1:0] LVL_ZERO = 13'h0000;
   localparam int               BUF_DEPTH = 2;

endpackage

// *** sim/fabric_reader.sv ***
// fabric reader model that takes words with random stalls
`timescale 1ns/10ps
module fabric_reader (
   // clock
   input  wire logic core_clk,
   // stall control and ready toward the block
   input  wire logic stall_en,
   output logic      rd_ready = 1'b1
);
   logic [7:0] lfsr = 8'h5a;
   // ready moves at the falling edge so the block samples it settled
   always @(negedge core_clk) begin
      lfsr     <= {lfsr[6:0], lfsr[7] ^ lfsr[5]};
      rd_ready <= !(stall_en && lfsr[0]);
   end
endmodule // fabric_reader

// *** sim/fifo_checker_asserts.sv ***
// port checker for the sram buffer block
`timescale 1ns/10ps
module fifo_checker #(
   parameter int DEPTH_MAX = 4096
) (
   // clock, reset and configuration
   input wire logic        core_clk, sys_rst, fifo_mode, init_en,
   input wire logic [2:0]  wr_width_sel, rd_width_sel,
   input wire logic [12:0] fifo_depth, almost_full_level,
   input wire logic [12:0] almost_empty_level, fill_level,
   // ports and flags
   input wire logic [7:0]  init_addr,
   input wire logic [11:0] wr_addr, rd_addr,
   input wire logic [17:0] init_data, wr_data, rd_data,
   input wire logic        wr_en, wr_ready, rd_en, rd_valid, rd_ready,
   input wire logic        full_flag, empty_flag,
   input wire logic        almost_full_flag, almost_empty_flag
);
   // ---------------------------------------------------------------
   // flags, refusals and read handshake
   // ---------------------------------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   reset_state_a: assert property ($fell(sys_rst) |->
      empty_flag && !full_flag && !rd_valid) else $error("reset state");
   empty_level_a: assert property (fifo_mode |->
      empty_flag == (fill_level == 13'h0000)) else $error("empty flag");
   almost_full_a: assert property (fifo_mode |->
      almost_full_flag == (fill_level >= almost_full_level))
      else $error("almost full");
   almost_empty_a: assert property (fifo_mode |->
      almost_empty_flag == (fill_level <= almost_empty_level))
      else $error("almost empty");
   full_refuse_a: assert property (fifo_mode && full_flag |->
      !wr_ready) else $error("write taken while full");
   preload_block_a: assert property (init_en |-> !wr_ready)
      else $error("write taken during preload");
   empty_read_a: assert property (fifo_mode && empty_flag && !wr_en
      |=> empty_flag) else $error("read left empty state");
   read_answer_a: assert property (fifo_mode && rd_en && !init_en
      && !empty_flag && !rd_valid |=> rd_valid) else $error("no read data");
   data_hold_a: assert property (rd_valid && !rd_ready |=>
      rd_valid && $stable(rd_data)) else $error("read data moved");
endmodule // fifo_checker
bind sram_fifo_block fifo_checker #(.DEPTH_MAX(DEPTH_MAX)) u_chk (.*);

// *** sim/testbench.sv ***
// self-checking bench for the sram buffer block
`timescale 1ns/10ps
module testbench;
   // ---------------------------------------------------------------
   // signals, model and helpers
   // ---------------------------------------------------------------
   logic        core_clk = 1'b0, sys_rst = 1'b1, fifo_mode = 1'b1;
   logic        init_en = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
   logic        stall_en = 1'b1, ok;
   logic [2:0]  wr_width_sel = 3'h0, rd_width_sel = 3'h0;
   logic [12:0] fifo_depth = 13'h0003, almost_full_level = 13'h0002;
   logic [12:0] almost_empty_level = 13'h0001, fill_level;
   logic [7:0]  init_addr = 8'h00;
   logic [11:0] wr_addr = 12'h000, rd_addr = 12'h000;
   logic [17:0] init_data = 18'h00000, wr_data = 18'h00000;
   logic [17:0] rd_data, got, want;
   logic        wr_ready, rd_valid, rd_ready, full_flag, empty_flag;
   logic        almost_full_flag, almost_empty_flag;
   int          failures = 0, num_checks = 0, seed = 32'h7457;
   int          wtab[5] = '{18, 9, 4, 2, 1};
   bit          bits[$];   // model contents, one entry per stored bit

   // free-running clock
   always #5 core_clk = ~core_clk;

   sram_fifo_block DUT (.*);
   fabric_reader partner (.*);

   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // one write, held for one cycle; refused words stay out of the model
   task automatic wr_word(input logic [17:0] d);
      int w;
      w = wtab[wr_width_sel];
      @(negedge core_clk);
      wr_en = 1'b1;
      wr_data = d;
      #1 ok = !fifo_mode || (bits.size() + w <= fifo_depth * w);
      check(wr_ready, ok);
      if (ok && fifo_mode) for (int i = 0; i < w; i++) bits.push_back(d[i]);
      @(negedge core_clk);
      wr_en = 1'b0;
   endtask

   // one read; waits for the partner's handshake under a bound
   task automatic rd_word;
      int i;
      @(negedge core_clk);
      rd_en = 1'b1;
      @(negedge core_clk);
      rd_en = 1'b0;
      // look just after the reader's update, before the sampling edge
      for (i = 0; i < 60; i++) begin
         #1;
         if (rd_valid === 1'b1 && rd_ready === 1'b1) break;
         @(negedge core_clk);
      end
      if (i == 60) begin
         failures++;
         test_done();
      end
      got = rd_data;
      @(negedge core_clk);
   endtask

   // take the expected word from the model and compare flags
   task automatic rd_check;
      int lvl;
      rd_word();
      want = 18'h00000;
      for (int i = 0; i < wtab[rd_width_sel]; i++) want[i] = bits.pop_front();
      lvl = bits.size() / wtab[rd_width_sel];
      check(got, want);
      check(fill_level, 18'(lvl));
      check(empty_flag, lvl == 0);
      check(almost_empty_flag, lvl <= almost_empty_level);
      check(almost_full_flag, lvl >= almost_full_level);
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (8) @(negedge core_clk);
      sys_rst = 1'b0;
      @(negedge core_clk);
      check(empty_flag, 1'b1);
      check(rd_valid, 1'b0);
      $display("reset test done");
      // each shape: overfill by one, drain, then read while empty
      for (int c = 0; c < 5; c++) begin
         wr_width_sel = 3'(c);
         rd_width_sel = 3'(c);
         for (int n = 0; n < 4; n++) wr_word(18'($random(seed)));
         check(full_flag, 1'b1);
         check(fill_level, 18'h00003);
         repeat (3) rd_check();
         @(negedge core_clk);
         rd_en = 1'b1;
         repeat (2) @(negedge core_clk);
         rd_en = 1'b0;
         check(rd_valid, 1'b0);
         check(fill_level, 18'h00000);
      end
      $display("shape test done");
      // narrow writes come back one bit at a time, lowest bit first
      wr_width_sel = 3'h2;
      rd_width_sel = 3'h4;
      fifo_depth = 13'h0002;
      wr_word(18'h0000a);
      wr_word(18'h00005);
      repeat (8) rd_check();
      $display("mixed width test done");
      // plain ram: addressed write, row preload, addressed reads
      fifo_mode = 1'b0;
      wr_width_sel = 3'h0;
      rd_width_sel = 3'h0;
      wr_addr = 12'h005;
      wr_word(18'h2a5c3);
      @(negedge core_clk);
      init_en = 1'b1;
      init_addr = 8'h07;
      init_data = 18'h1b0f6;
      #1 check(wr_ready, 1'b0);
      @(negedge core_clk);
      init_en = 1'b0;
      rd_addr = 12'h005;
      rd_word();
      check(got, 18'h2a5c3);
      rd_addr = 12'h007;
      rd_word();
      check(got, 18'h1b0f6);
      $display("ram and preload test done");
      test_done();
   end
endmodule // testbench
